// ==== hdl/dhs_loop_ctrl.sv ====
// dhs_loop_ctrl.sv: per-loop control for hitless switching, slope and offset limits, quick lock
// assumes reference selection, lock detection and phase measurement come from outside as ports
`timescale 1ns/1ps
`default_nettype none
`include "dhs_map.svh"
module dhs_loop_ctrl #(
	parameter int FW        = `DHS_FREQ_W,
	parameter int PW        = `DHS_PHASE_W,
	parameter int MS_CYCLES = `DHS_MS_CYCLES,
	parameter int SEC_CYC   = `DHS_CLK_HZ
) (
	input  wire logic                     i_clk,
	input  wire logic                     i_sys_rst,
	input  wire logic                     i_hitless_switch_en,
	input  wire logic                     i_hitless_type2,
	input  wire logic [`DHS_PSL_W-1:0]    i_slope_limit_field,
	input  wire logic                     i_phase_slope_limit_en,
	input  wire logic [FW-1:0]            i_offset_range_field,
	input  wire logic [4:0]               i_quick_lock_options,
	input  wire logic [9:0]               i_quick_lock_state_sel,
	input  wire logic [`DHS_PSL_W-1:0]    i_quick_lock_slope_field,
	input  wire logic [`DHS_BW_W-1:0]     i_quick_lock_bandwidth_field,
	input  wire logic [`DHS_PSL_W-1:0]    i_quick_lock_freq_slope_field,
	input  wire logic                     i_freq_slope_cap_en,
	input  wire logic [`DHS_PRE_MS_W-1:0] i_preacq_ms,
	input  wire logic [`DHS_BW_W-1:0]     i_normal_bandwidth,
	input  wire logic                     i_any_ref_valid,
	input  wire logic [3:0]               i_ref_sel,
	input  wire logic                     i_lock_det,
	input  wire logic                     i_meas_valid,
	input  wire logic [PW-1:0]            i_meas_phase,
	input  wire logic [FW-1:0]            i_meas_freq,
	input  wire logic [FW-1:0]            i_loop_freq,
	output logic                          o_holdover_alarm,
	output logic                          o_holdover,
	output logic                          o_hitless_pulse,
	output logic                          o_sat_phase_shift,
	output logic [PW-1:0]                 o_pd_zero,
	output logic [FW-1:0]                 o_fod_freq,
	output logic                          o_fod_write,
	output logic [PW-1:0]                 o_phase_step,
	output logic                          o_phase_step_en,
	output logic                          o_pd_lpf_bypass,
	output logic [`DHS_BW_W-1:0]          o_bandwidth,
	output logic [`DHS_PSL_W-1:0]         o_psl_active,
	output logic                          o_psl_active_en,
	output logic [2:0]                    o_state,
	output logic [2:0]                    o_ql_method
);
	import dhs_pkg::*;

	dhs_state_t state_q, state_d;
	dhs_ql_t    ql_q, ql_d;
	logic [3:0]    ref_q;
	logic          acq_kind_q;
	logic [PW-1:0] zero_q;
	logic [FW-1:0] fod_q;
	logic          fod_wr_q;
	logic [PW-1:0] pstep_q;
	logic          pstep_q_en;
	logic          hit_q;
	logic [31:0]   sec_q;
	logic          rate_tick;

	dhs_slew_if #(.W(FW)) fslew ();

	// clamp the request symmetrically to +/- range
	function automatic logic [FW-1:0] clamp_off(input logic [FW-1:0] v, input logic [FW-1:0] lim);
		logic [FW-1:0] neg;
		neg = -lim;
		if ($signed(v) > $signed(lim))
			clamp_off = lim;
		else if ($signed(v) < $signed(neg))
			clamp_off = neg;
		else
			clamp_off = v;
	endfunction

	function automatic logic method_on(input logic [4:0] opt, input logic [9:0] sel, input int idx, input logic rec);
		method_on = opt[idx] && sel[2*idx + (rec ? 1 : 0)];
	endfunction

	// decode of triggers
	logic ref_changed;
	logic hit_from_lock;
	logic hit_from_ho;
	logic rec_kind;
	logic m_f;
	logic m_p;
	logic m_pull;
	logic m_w;
	logic m_pre;
	logic pre_busy;
	logic pre_start;
	logic [FW-1:0] freq_err;
	logic [FW-1:0] freq_tgt;

	assign ref_changed   = (i_ref_sel != ref_q);
	assign hit_from_lock = i_hitless_switch_en && state_q == DHS_LOCKED && ref_changed && i_any_ref_valid;
	assign hit_from_ho   = i_hitless_switch_en && state_q == DHS_HOLDOVER && i_any_ref_valid;
	assign rec_kind      = acq_kind_q;
	assign m_f    = method_on(i_quick_lock_options, i_quick_lock_state_sel, `DHS_QL_FSNAP, rec_kind);
	assign m_p    = method_on(i_quick_lock_options, i_quick_lock_state_sel, `DHS_QL_PSNAP, rec_kind);
	assign m_pull = method_on(i_quick_lock_options, i_quick_lock_state_sel, `DHS_QL_PULLIN, rec_kind);
	assign m_w    = method_on(i_quick_lock_options, i_quick_lock_state_sel, `DHS_QL_WIDE, rec_kind);
	assign m_pre  = i_quick_lock_options[`DHS_QL_PREACQ] && !rec_kind;
	assign freq_err = i_meas_freq - i_loop_freq;
	assign freq_tgt = clamp_off(i_loop_freq + freq_err, i_offset_range_field);
	assign rate_tick = (sec_q == 32'(SEC_CYC - 1));

	// precedence order, psnap shadows pull-in so the two never run together
	always_comb begin
		ql_d = DHS_QL_NONE;
		if (state_q == DHS_ACQUIRE || state_q == DHS_REACQ) begin
			case (ql_q)
				DHS_QL_NONE: begin
					if (m_f)                            ql_d = DHS_QL_F;
					else if (m_p)                       ql_d = DHS_QL_P;
					else if (m_pull)                    ql_d = DHS_QL_PULL;
					else if (m_pre)                     ql_d = DHS_QL_PRE;
					else if (m_w)                       ql_d = DHS_QL_W;
					else                                ql_d = DHS_QL_NONE;
				end
				DHS_QL_F:    ql_d = (i_meas_valid && fslew.settled) ? (m_p ? DHS_QL_P : m_pull ? DHS_QL_PULL :
				                    m_pre ? DHS_QL_PRE : m_w ? DHS_QL_W : DHS_QL_F) : DHS_QL_F;
				DHS_QL_P:    ql_d = i_meas_valid ? (m_pre ? DHS_QL_PRE : m_w ? DHS_QL_W : DHS_QL_P) : DHS_QL_P;
				DHS_QL_PULL: ql_d = i_lock_det ? (m_pre ? DHS_QL_PRE : m_w ? DHS_QL_W : DHS_QL_PULL) : DHS_QL_PULL;
				DHS_QL_PRE:  ql_d = pre_busy ? DHS_QL_PRE : (m_w ? DHS_QL_W : DHS_QL_PRE);
				DHS_QL_W:    ql_d = DHS_QL_W;
				default:     ql_d = DHS_QL_NONE;
			endcase
		end
	end

	assign pre_start = (ql_q != DHS_QL_PRE) && (ql_d == DHS_QL_PRE);

	// lock seen during pull-in only ends the pull; later relaxing steps still run before lock is declared
	logic pull_more;
	assign pull_more = (ql_q == DHS_QL_PULL) && (m_pre || m_w);

	always_comb begin
		state_d = state_q;
		case (state_q)
			DHS_FREE:     state_d = i_any_ref_valid ? DHS_ACQUIRE : DHS_HOLDOVER;
			DHS_ACQUIRE,
			DHS_REACQ:    state_d = !i_any_ref_valid ? DHS_HOLDOVER :
			                        ((i_lock_det && !pull_more) ? DHS_LOCKED : state_q);
			DHS_LOCKED: begin
				if (!i_any_ref_valid)   state_d = DHS_HOLDOVER;
				else if (hit_from_lock) state_d = DHS_HITLESS;
				else if (ref_changed)   state_d = DHS_REACQ;
			end
			DHS_HOLDOVER: begin
				if (hit_from_ho)          state_d = DHS_HITLESS;
				else if (i_any_ref_valid) state_d = DHS_REACQ;
			end
			// temporary holdover: measure start offset then track
			DHS_HITLESS:  state_d = !i_any_ref_valid ? DHS_HOLDOVER : (i_meas_valid ? DHS_LOCKED : DHS_HITLESS);
			default:      state_d = DHS_FREE;
		endcase
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state_q    <= DHS_FREE;
			ql_q       <= DHS_QL_NONE;
			ref_q      <= 4'h0;
			acq_kind_q <= 1'b0;
			sec_q      <= 32'h0;
		end else begin
			state_q <= state_d;
			ql_q    <= ql_d;
			ref_q   <= i_ref_sel;
			sec_q   <= rate_tick ? 32'h0 : sec_q + 32'h1;
			if (state_q == DHS_LOCKED || state_q == DHS_HOLDOVER)
				acq_kind_q <= 1'b1; // after first lock or holdover, later acquisitions are reacquire
		end
	end

	// zero point, snaps and event pulse
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			zero_q     <= '0;
			fod_q      <= '0;
			fod_wr_q   <= 1'b0;
			pstep_q    <= '0;
			pstep_q_en <= 1'b0;
			hit_q      <= 1'b0;
		end else begin
			hit_q      <= (state_q != DHS_HITLESS) && (state_d == DHS_HITLESS);
			fod_wr_q   <= (ql_q == DHS_QL_F) || (state_q == DHS_HOLDOVER);
			fod_q      <= clamp_off(fslew.value, i_offset_range_field);
			pstep_q_en <= (ql_q == DHS_QL_P) && i_meas_valid;
			if ((ql_q == DHS_QL_P) && i_meas_valid)
				pstep_q <= i_meas_phase;
			if (state_q == DHS_HITLESS && i_meas_valid)
				zero_q <= i_meas_phase;
			else if (state_q == DHS_ACQUIRE || state_q == DHS_REACQ)
				zero_q <= '0;
		end
	end

	// snap target is the clamped measured frequency, otherwise the loop's own
	assign fslew.target    = (ql_q == DHS_QL_F) ? freq_tgt : clamp_off(i_loop_freq, i_offset_range_field);
	assign fslew.load      = (ql_q != DHS_QL_F);
	assign fslew.step      = i_quick_lock_freq_slope_field;
	assign fslew.unlimited = !i_freq_slope_cap_en;

	dhs_slew #(.W(FW)) u_fslew (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_tick    (rate_tick),
		.s         (fslew)
	);

	dhs_pretimer #(.MS_CYCLES(MS_CYCLES)) u_pre (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_start   (pre_start),
		.i_ms      (i_preacq_ms),
		.o_busy    (pre_busy),
		.o_tick    ()
	);

	// relaxed limits apply during the pre-acquisition and wide steps of acquisition; normal ones return on lock, the pre-acquisition bandwidth one cycle later
	logic relaxing;
	assign relaxing = (ql_q == DHS_QL_W || ql_q == DHS_QL_PRE) && (state_q == DHS_ACQUIRE || state_q == DHS_REACQ);

	assign o_bandwidth = (ql_q == DHS_QL_PRE) ? `DHS_BW_MAX :
	                     relaxing ? i_quick_lock_bandwidth_field : i_normal_bandwidth;
	// zero field means unlimited: loop bandwidth alone bounds the phase rate
	assign o_psl_active    = relaxing ? i_quick_lock_slope_field : i_slope_limit_field;
	assign o_psl_active_en = i_phase_slope_limit_en && (o_psl_active != `DHS_PSL_UNLIMITED);

	assign o_holdover        = (state_q == DHS_HOLDOVER) || (state_q == DHS_HITLESS);
	assign o_holdover_alarm  = (state_q == DHS_HOLDOVER);
	assign o_hitless_pulse   = hit_q;
	// type two leaves satellite outputs a small random step; flagged per event
	assign o_sat_phase_shift = hit_q && i_hitless_type2;
	// type one keeps zero tied to new reference frequency via the measured offset
	assign o_pd_zero         = i_hitless_type2 ? zero_q : zero_q + PW'(freq_err);
	assign o_fod_freq        = fod_q;
	assign o_fod_write       = fod_wr_q;
	assign o_phase_step      = pstep_q;
	assign o_phase_step_en   = pstep_q_en;
	assign o_pd_lpf_bypass   = (ql_q == DHS_QL_PULL);
	assign o_state           = state_q;
	assign o_ql_method       = ql_q;
endmodule
`default_nettype wire

// ==== hdl/dhs_map.svh ====
// dhs_map.svh: offsets, field positions and timing counts for the loop control block
// assumes inclusion by bare name from the loop control and pretimer modules
`ifndef DHS_MAP_SVH
`define DHS_MAP_SVH

`define DHS_CLK_HZ          20000000
`define DHS_MS_CYCLES       (`DHS_CLK_HZ / 1000)
`define DHS_PSL_W           16
`define DHS_PSL_UNLIMITED   16'h0000
`define DHS_FREQ_W          32
`define DHS_PHASE_W         32
`define DHS_BW_W            8
`define DHS_BW_MAX          8'hFF
`define DHS_PRE_MS_W        8
// quick-lock option bit positions
`define DHS_QL_FSNAP        0
`define DHS_QL_PSNAP        1
`define DHS_QL_PULLIN       2
`define DHS_QL_WIDE         3
`define DHS_QL_PREACQ       4
// state selection: bit0 initial acquire, bit1 reacquire
`define DHS_SEL_ACQ         0
`define DHS_SEL_REC         1
`define DHS_MEAS_WAIT       16'h0040

`endif

// ==== hdl/dhs_pkg.sv ====
// dhs_pkg.sv: types shared by the loop control block
// assumes dhs_map.svh holds the numeric constants
package dhs_pkg;
	typedef enum logic [2:0] {
		DHS_FREE     = 3'b000,
		DHS_ACQUIRE  = 3'b001,
		DHS_LOCKED   = 3'b010,
		DHS_HOLDOVER = 3'b011,
		DHS_HITLESS  = 3'b100,
		DHS_REACQ    = 3'b101
	} dhs_state_t;

	typedef enum logic [2:0] {
		DHS_QL_NONE  = 3'b000,
		DHS_QL_F     = 3'b001,
		DHS_QL_P     = 3'b010,
		DHS_QL_PULL  = 3'b011,
		DHS_QL_PRE   = 3'b100,
		DHS_QL_W     = 3'b101
	} dhs_ql_t;
endpackage

// ==== hdl/dhs_pretimer.sv ====
// dhs_pretimer.sv: millisecond countdown for the wide-open pre-acquisition step
// assumes a 20 MHz clock; ms length is a parameter for short simulations
`timescale 1ns/1ps
`default_nettype none
`include "dhs_map.svh"
module dhs_pretimer #(
	parameter int MS_CYCLES = `DHS_MS_CYCLES
) (
	input  wire logic                     i_clk,
	input  wire logic                     i_sys_rst,
	input  wire logic                     i_start,
	input  wire logic [`DHS_PRE_MS_W-1:0] i_ms,
	output logic                          o_busy,
	output logic                          o_tick
);
	logic [31:0]              cyc_q;
	logic [`DHS_PRE_MS_W-1:0] ms_q;
	logic                     ms_end;

	assign ms_end = (cyc_q == 32'(MS_CYCLES - 1));
	assign o_busy = (ms_q != '0);
	assign o_tick = ms_end;

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			cyc_q <= '0;
			ms_q  <= '0;
		end else if (i_start) begin
			cyc_q <= '0;
			ms_q  <= i_ms;
		end else begin
			cyc_q <= ms_end ? 32'h0 : cyc_q + 32'h1;
			if (o_busy && ms_end)
				ms_q <= ms_q - 1'b1;
		end
	end
endmodule
`default_nettype wire

// ==== hdl/dhs_slew.sv ====
// dhs_slew.sv: moves a value toward a target by at most step per tick
// assumes tick pacing is applied by the caller via step units
`timescale 1ns/1ps
`default_nettype none
module dhs_slew #(
	parameter int W = 32
) (
	input  wire logic i_clk,
	input  wire logic i_sys_rst,
	input  wire logic i_tick,
	dhs_slew_if.lim   s
);
	logic [W-1:0] val_q;
	logic [W-1:0] diff_up;
	logic [W-1:0] diff_dn;
	logic         above;
	logic [W-1:0] step_w;

	assign above   = $signed(s.target) > $signed(val_q);
	assign diff_up = s.target - val_q;
	assign diff_dn = val_q - s.target;
	assign step_w  = {{(W-16){1'b0}}, s.step};
	assign s.value   = val_q;
	assign s.settled = (val_q == s.target);

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			val_q <= '0;
		end else if (s.load || s.unlimited) begin
			val_q <= s.target;
		end else if (i_tick && above) begin
			val_q <= (diff_up > step_w) ? val_q + step_w : s.target;
		end else if (i_tick && !s.settled) begin
			val_q <= (diff_dn > step_w) ? val_q - step_w : s.target;
		end
	end
endmodule
`default_nettype wire

// ==== hdl/dhs_slew_if.sv ====
// dhs_slew_if.sv: signals between loop controller and its rate limiter
// assumes one clock shared by both ends
`timescale 1ns/1ps
`default_nettype none
interface dhs_slew_if #(parameter int W = 32);
	logic         load;
	logic [W-1:0] target;
	logic [15:0]  step;
	logic         unlimited;
	logic [W-1:0] value;
	logic         settled;
	modport ctrl (output load, output target, output step, output unlimited, input value, input settled);
	modport lim  (input load, input target, input step, input unlimited, output value, output settled);
endinterface
`default_nettype wire

// ==== testbench/dhs_loop_ctrl_checker.sv ====
// dhs_loop_ctrl_checker.sv: concurrent checks on the loop control block ports
// assumes a bind onto dhs_loop_ctrl from the bench top file
`timescale 1ns/1ps
`default_nettype none
module dhs_loop_ctrl_checker #(
	parameter int PW = 32
) (
	input wire logic          i_clk,
	input wire logic          i_sys_rst,
	input wire logic          i_hitless_switch_en,
	input wire logic          i_hitless_type2,
	input wire logic          i_any_ref_valid,
	input wire logic [3:0]    i_ref_sel,
	input wire logic          i_meas_valid,
	input wire logic [PW-1:0] i_meas_phase,
	input wire logic          o_holdover_alarm,
	input wire logic          o_holdover,
	input wire logic          o_hitless_pulse,
	input wire logic          o_sat_phase_shift,
	input wire logic [PW-1:0] o_pd_zero,
	input wire logic          o_pd_lpf_bypass,
	input wire logic [2:0]    o_state,
	input wire logic [2:0]    o_ql_method
);
	import dhs_pkg::*;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	sequence s_enter_hitless;
		o_state != DHS_HITLESS ##1 o_state == DHS_HITLESS;
	endsequence
	sequence s_single_pulse;
		o_hitless_pulse ##1 !o_hitless_pulse;
	endsequence
	a_alarm_true_ho: assert property (o_holdover_alarm == (o_state == DHS_HOLDOVER))
		else $error("holdover alarm differs from holdover state");
	a_hitless_quiet: assert property (o_state == DHS_HITLESS |-> o_holdover && !o_holdover_alarm)
		else $error("hitless event not a silent holdover");
	a_ref_change_hit: assert property (o_state == DHS_LOCKED && i_hitless_switch_en && i_any_ref_valid
		&& $changed(i_ref_sel) |=> o_state == DHS_HITLESS) else $error("reference change did not start hitless");
	a_hitless_pulse: assert property (s_enter_hitless |-> s_single_pulse)
		else $error("hitless entry pulse missing or long");
	a_sat_shift_type: assert property (o_sat_phase_shift == (o_hitless_pulse && i_hitless_type2))
		else $error("satellite shift flag wrong");
	a_zero_capture: assert property (o_state == DHS_HITLESS && i_meas_valid && i_hitless_type2
		|=> o_state == DHS_LOCKED && o_pd_zero == $past(i_meas_phase)) else $error("zero point not captured");
	a_zero_kept: assert property (o_state == DHS_LOCKED && $past(o_state) == DHS_LOCKED |-> $stable(o_pd_zero))
		else $error("zero point moved while tracking");
	a_leave_ho_hit: assert property (o_state == DHS_HOLDOVER && i_any_ref_valid && i_hitless_switch_en
		|=> o_state == DHS_HITLESS) else $error("holdover exit did not start hitless");
	a_leave_ho_plain: assert property (o_state == DHS_HOLDOVER && i_any_ref_valid && !i_hitless_switch_en
		|=> o_state == DHS_REACQ) else $error("disabled hitless still used");
	a_all_invalid: assert property (o_state == DHS_LOCKED && !i_any_ref_valid |=> o_state == DHS_HOLDOVER)
		else $error("no holdover with all references invalid");
	a_bypass_pull: assert property (o_pd_lpf_bypass == (o_ql_method == DHS_QL_PULL))
		else $error("detector bypass not tied to pull-in");
endmodule
`default_nettype wire

// ==== testbench/dhs_loop_ctrl_tb.sv ====
// dhs_loop_ctrl_tb.sv: self-checking bench for the loop control block
// assumes hdl/ compiled first; timers shortened through parameters
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
	$display("BAD %s expected %0h seen %0h", nm, e, g); end end
module dhs_loop_ctrl_tb;
	import dhs_pkg::*;
	typedef struct packed {logic en; logic av; logic [3:0] rs; logic mv; logic [2:0] st; logic ho; logic al;} dhs_row_t;
	logic i_clk, i_sys_rst, en, t2, av, lock, mv, fcap;
	logic [3:0] rs;
	logic [4:0] opts;
	logic [31:0] phase;
	logic [7:0] bw, sbw;
	logic [2:0] st, qm;
	logic ho, al, hp, sat, fw, pse, byp, pen;
	logic [31:0] pz, ff, ps;
	logic [15:0] pact;
	logic        psl_en;
	logic [15:0] phase_slope_limit;
	logic [9:0]  qsel;
	logic [31:0] orng, mfreq, lfreq;
	int bad_count, num_checks, cyc;
	dhs_row_t rows [7];
	dhs_loop_ctrl #(.MS_CYCLES(4), .SEC_CYC(8)) dhs_loop_ctrl_i (
		.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_hitless_switch_en(en), .i_hitless_type2(t2),
		.i_slope_limit_field(phase_slope_limit), .i_phase_slope_limit_en(psl_en), .i_offset_range_field(orng),
		.i_quick_lock_options(opts), .i_quick_lock_state_sel(qsel), .i_quick_lock_slope_field(16'h0100),
		.i_quick_lock_bandwidth_field(8'hC0), .i_quick_lock_freq_slope_field(16'h0400), .i_freq_slope_cap_en(fcap),
		.i_preacq_ms(8'h02), .i_normal_bandwidth(bw), .i_any_ref_valid(av), .i_ref_sel(rs), .i_lock_det(lock),
		.i_meas_valid(mv), .i_meas_phase(phase), .i_meas_freq(mfreq), .i_loop_freq(lfreq),
		.o_holdover_alarm(al), .o_holdover(ho), .o_hitless_pulse(hp), .o_sat_phase_shift(sat), .o_pd_zero(pz),
		.o_fod_freq(ff), .o_fod_write(fw), .o_phase_step(ps), .o_phase_step_en(pse), .o_pd_lpf_bypass(byp),
		.o_bandwidth(sbw), .o_psl_active(pact), .o_psl_active_en(pen), .o_state(st), .o_ql_method(qm)
	);
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// polls just after each edge so a one-cycle method is not missed
	task automatic wait_for(input logic [2:0] what, input bit is_state);
		int n;
		n = 0;
		while (((is_state ? st : qm) !== what) && n < 300) begin
			@(posedge i_clk);
			#1;
			n++;
		end
		`CHK("wait", what, (is_state ? st : qm))
	endtask
	initial begin
		i_clk = 0;
		forever #25 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 4000) begin
			bad_count++;
			final_report();
		end
	end
	initial begin
		{en, t2, av, lock, mv, fcap, i_sys_rst} = 7'b1110001;
		rs = 4'h0; opts = 5'h00; phase = 32'h0000_1234; bw = 8'h20;
		phase_slope_limit = 16'h0010; psl_en = 1'b1; qsel = 10'h3FF;
		orng = 32'h0000_1000; // range covers the measured input offset
		mfreq = 32'h1000_0010; lfreq = 32'h1000_0000;
		bad_count = 0; num_checks = 0; cyc = 0;
		rows = '{'{1, 1, 4'h1, 0, DHS_HITLESS, 1, 0}, '{1, 1, 4'h1, 1, DHS_LOCKED, 0, 0},
			'{1, 0, 4'h1, 0, DHS_HOLDOVER, 1, 1}, '{1, 1, 4'h1, 0, DHS_HITLESS, 1, 0},
			'{1, 1, 4'h1, 1, DHS_LOCKED, 0, 0}, '{0, 0, 4'h1, 0, DHS_HOLDOVER, 1, 1},
			'{0, 1, 4'h1, 0, DHS_REACQ, 0, 0}};
		repeat (5) @(posedge i_clk);
		#1;
		`CHK("rst_state", DHS_FREE, st)
		`CHK("rst_bw", bw, sbw)
		`CHK("rst_out", 4'h0, {hp, fw, pse, al})
		repeat (5) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		lock <= 1'b1;
		wait_for(DHS_LOCKED, 1);
		$display("test reset and first lock done");
		foreach (rows[i]) begin
			@(posedge i_clk);
			en <= rows[i].en; av <= rows[i].av; rs <= rows[i].rs; mv <= rows[i].mv;
			phase <= phase + 32'h0000_0101;
			@(posedge i_clk);
			#1;
			`CHK("row_state", rows[i].st, st)
			`CHK("row_flags", {rows[i].ho, rows[i].al}, {ho, al})
		end
		$display("test hitless table done");
		for (int k = 0; k < 2; k++) begin
			@(posedge i_clk);
			i_sys_rst <= 1'b1;
			opts <= k ? 5'b11101 : 5'b11011; // slow reference: snaps first, relaxing steps after
			fcap <= k[0];
			{lock, mv, en, av} <= 4'b0111;
			repeat (2) @(posedge i_clk);
			i_sys_rst <= 1'b0;
			wait_for(DHS_QL_F, 0);
			wait_for(k ? DHS_QL_PULL : DHS_QL_P, 0);
			if (k) begin
				`CHK("bypass", 1'b1, byp)
				lock <= 1'b1;
				@(posedge i_clk);
				lock <= 1'b0;
			end
			wait_for(DHS_QL_PRE, 0);
			@(posedge i_clk);
			#1;
			`CHK("pre_bw", `DHS_BW_MAX, sbw)
			wait_for(DHS_QL_W, 0);
			@(posedge i_clk);
			#1;
			`CHK("wide_bw", 8'hC0, sbw)
			`CHK("wide_psl", 16'h0100, pact)
			lock <= 1'b1;
			wait_for(DHS_LOCKED, 1);
			@(posedge i_clk);
			#1;
			`CHK("norm_bw", bw, sbw)
			`CHK("norm_psl", 16'h0010, pact)
			`CHK("norm_psl_en", 1'b1, pen)
			$display("test quick lock pass %0d done", k);
		end
		final_report();
	end
endmodule
bind dhs_loop_ctrl dhs_loop_ctrl_checker #(.PW(PW)) chk_i (
	.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_hitless_switch_en(i_hitless_switch_en),
	.i_hitless_type2(i_hitless_type2), .i_any_ref_valid(i_any_ref_valid), .i_ref_sel(i_ref_sel),
	.i_meas_valid(i_meas_valid), .i_meas_phase(i_meas_phase), .o_holdover_alarm(o_holdover_alarm),
	.o_holdover(o_holdover), .o_hitless_pulse(o_hitless_pulse), .o_sat_phase_shift(o_sat_phase_shift),
	.o_pd_zero(o_pd_zero), .o_pd_lpf_bypass(o_pd_lpf_bypass), .o_state(o_state), .o_ql_method(o_ql_method)
);
`default_nettype wire
